// ===== tswd_bench.sv
// Self-checking bench for the two-stage watchdog supervisor
`timescale 1ns/1ns
`include "tswd_params.svh"
module tswd_bench;
    localparam int T = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic [1:0] base_sel = 2'h0;
    tswd_pkg::tswd_bus_req_t bus_req;
    tswd_pkg::tswd_pins_t pins_async = '0;
    logic [7:0] bus_rdata;
    logic nmi_irq;
    logic master_reset;
    logic power_fail_out_n;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int m_lock;
    int m_wd;
    int n;
    logic [15:0] base;
    logic [7:0] d;

    always #10 clk_sys = ~clk_sys;

    // Short tick keeps the longest tested period within the run budget
    tswd_top #(.TICK_CYC(T), .RST_HOLD(4)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
        .base_sel(base_sel), .bus_req(bus_req), .pins_async(pins_async), .bus_rdata(bus_rdata),
        .nmi_irq(nmi_irq), .master_reset(master_reset), .power_fail_out_n(power_fail_out_n));
    tswd_host host (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Model update: enable only moves while the lock bit is clear
    task automatic mw(input int ofs, input int v);
        if (ofs == 2)
            m_lock = v & 8'h05;
        if (ofs == 6)
            m_wd = m_lock[2] ? (m_wd & 8'h80) | (v & 8'h70) : v & 8'hf0;
        host.wr(base + 16'(ofs), 8'(v));
    endtask

    task automatic mr(input string what, input int ofs, input int exp);
        host.rd(base + 16'(ofs), d);
        chk(what, {24'h0, d}, exp);
    endtask

    task automatic board_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        m_lock = 8'h05;
        m_wd = 8'h70;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_ev(input bit pick_rst, output int c);
        c = 0;
        while (((pick_rst ? master_reset : nmi_irq) !== 1'b1) && c < 5000) begin
            @(posedge clk_sys);
            #1;
            c++;
        end
    endtask

    task automatic arm(input int code);
        mw(2, 8'h01);
        mw(8, 8'h01);
        mw(6, 8'h80 | (code << 4));
        mw(2, 8'h05);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hcee1));
        n = $urandom_range(2, 0);
        base_sel <= 2'(n);
        base = `TSWD_BASE0 + 16'(n) * 16'h0100;
        m_lock = 8'h05;
        m_wd = 8'h70;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        mr("wdog_rst", 6, 8'h70);
        mr("lock_rst", 2, 8'h05);
        mr("sys_rst", 1, 8'h00);
        mr("unmapped", 3, 8'h00);
        for (int k = 0; k < 8; k++) begin
            mw(6, 8'h80 | (k << 4));
            mr("locked_sel", 6, m_wd);
        end
        for (int b = 0; b < 4; b++) begin
            base_sel <= 2'(b);
            host.rd(`TSWD_BASE0 + 16'(b) * 16'h0100 + `TSWD_OFS_WDOG, d);
            chk("base_dec", {24'h0, d}, b < 3 ? m_wd : 0);
        end
        base_sel <= 2'(n);
        // Disabled watchdog with NMI enabled must stay silent past a full 011 period
        mw(8, 8'h01);
        mw(6, 8'hb0);
        wait_ev(0, n);
        chk("idle_no_nmi", n, 5000);
        chk("idle_no_rst", master_reset, 0);
        for (int k = 0; k < 3; k++) begin
            arm(k);
            wait_ev(0, n);
            chk("nmi_time", n >= (16 << 2 * k) * T - 2 && n <= (16 << 2 * k) * T + 4, 1);
            wait_ev(1, n);
            chk("rst_time", n >= 8 * T - 4 && n <= 8 * T + 2, 1);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("rst_hold", master_reset, 1);
            board_reset();
            mr("hist_set", 1, 8'h02);
            mr("dis_after", 6, 8'h70);
            mw(2, 8'h04);
            mw(2, 8'h05);
            mr("hist_clr", 1, 8'h00);
        end
        // Longest select armed, then switched off before it can expire
        arm(7);
        mw(2, 8'h01);
        mw(6, 8'h70);
        mw(2, 8'h05);
        mr("dis_sel7", 6, m_wd);
        chk("sel7_quiet", nmi_irq, 0);
        // Masked watchdog source gives a reset but no NMI
        arm(0);
        mw(8, 8'h00);
        wait_ev(1, n);
        chk("masked_nmi", nmi_irq, 0);
        board_reset();
        // Retrigger in the second stage cancels the reset and uses the new select
        arm(0);
        wait_ev(0, n);
        mw(6, 8'h90);
        mw(7, 8'h01);
        mr("w1c_wd", 7, 8'h00);
        wait_ev(1, n);
        chk("cancel_time", n >= 72 * T - 12 && n <= 72 * T + 2, 1);
        board_reset();
        // Battery source latches while enabled
        mw(8, 8'h02);
        pins_async <= '{supply_fail: 1'b1, battery_low: 1'($urandom_range(1, 1))};
        repeat (5) @(posedge clk_sys);
        #1;
        chk("pfo_pin", power_fail_out_n, 0);
        host.rd(`TSWD_ADDR_PFO, d);
        chk("pfo_rd", d[1], 0);
        // History flag is still set from the reset of the cancel scenario
        mr("sys_pf", 1, 8'h03);
        pins_async <= '0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk("bat_latch", nmi_irq, 1);
        host.rd(`TSWD_ADDR_PFO, d);
        chk("pfo_good", d[1], 1);
        mw(7, 8'h02);
        mr("w1c_bat", 7, 8'h00);
        wrap_up();
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            wrap_up();
        end
    end
endmodule

// ===== tswd_host.sv
// Host processor model issuing single-cycle register accesses
`timescale 1ns/1ns
module tswd_host (
    input wire logic clk_sys,
    output tswd_pkg::tswd_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata
);
    initial bus_req = '0;

    // ----------------------------------------
    // Accesses
    // ----------------------------------------
    // Released lines carry the inverse of the last value, so stale data is never mistaken for live
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        #1 v = bus_rdata;
    endtask
endmodule

// ===== tswd_params.svh
// Offsets, field positions, reset values and timing counts of the watchdog supervisor
`ifndef TSWD_PARAMS_SVH
`define TSWD_PARAMS_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define TSWD_BASE0 16'h0190
`define TSWD_BASE1 16'h0290
`define TSWD_BASE2 16'h0390
`define TSWD_OFS_SYS 16'h0001
`define TSWD_OFS_LOCK 16'h0002
`define TSWD_OFS_WDOG 16'h0006
`define TSWD_OFS_ISTAT 16'h0007
`define TSWD_OFS_IEN 16'h0008
`define TSWD_ADDR_PFO 16'h4031

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSWD_LOCK_BIT 2
`define TSWD_HCLR_BIT 0
`define TSWD_EN_BIT 7
`define TSWD_SEL_LSB 4
`define TSWD_SYS_PF_BIT 0
`define TSWD_SYS_WDO_BIT 1
`define TSWD_PFO_BIT 1
`define TSWD_INT_WD 0
`define TSWD_INT_BAT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSWD_RST_LOCK 8'h05
`define TSWD_RST_WDOG 8'h70

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSWD_TICK_NS 1080000
`define TSWD_CLK_NS 20
`define TSWD_S1_BASE_TICKS 16
`define TSWD_S2_TICKS 8
`define TSWD_RST_HOLD_CYC 16

`endif

// ===== tswd_pkg.sv
// Types shared by the watchdog supervisor
package tswd_pkg;

    typedef enum logic [1:0] {
        TSWD_IDLE  = 2'b00,
        TSWD_ARM   = 2'b01,
        TSWD_GRACE = 2'b10,
        TSWD_RESET = 2'b11
    } tswd_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tswd_bus_req_t;

    typedef struct packed {
        logic supply_fail;
        logic battery_low;
    } tswd_pins_t;

endpackage

// ===== tswd_top.sv
// Two-stage watchdog supervisor with power-fail status and reset history
`timescale 1ns/1ns
`include "tswd_params.svh"

module tswd_top #(
    parameter int unsigned TICK_CYC = `TSWD_TICK_NS / `TSWD_CLK_NS,
    parameter int unsigned RST_HOLD = `TSWD_RST_HOLD_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic [1:0] base_sel,
    input tswd_pkg::tswd_bus_req_t bus_req,
    input tswd_pkg::tswd_pins_t pins_async,
    output logic [7:0] bus_rdata,
    output logic nmi_irq,
    output logic master_reset,
    output logic power_fail_out_n
);

    localparam int unsigned PW = (TICK_CYC > 2) ? $clog2(TICK_CYC) : 1;
    localparam int unsigned HW = (RST_HOLD > 2) ? $clog2(RST_HOLD) : 1;
    localparam int unsigned CW = 19;

    function automatic logic [CW-1:0] s1_period(input logic [2:0] sel);
        s1_period = CW'(`TSWD_S1_BASE_TICKS) << {sel, 1'b0};
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    tswd_pkg::tswd_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [PW-1:0] pre_r;
    logic [HW-1:0] hold_r, hold_nxt;
    logic lock_r, hclr_n_r, wd_en_r, wdo_r;
    logic [2:0] wd_sel_r;
    logic [1:0] ien_r, istat_r, s1_r, s2_r;
    logic [7:0] rdata_r;
    logic nmi_r, mrst_r, pfo_n_r;
    logic wd_evt, rst_evt;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
        end else begin
            s1_r <= pins_async;
            s2_r <= s1_r;
        end
    end

    wire bat_low = s2_r[0];
    wire sup_fail = s2_r[1];

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire [15:0] base_w = (base_sel == 2'h0) ? `TSWD_BASE0 :
                         (base_sel == 2'h1) ? `TSWD_BASE1 : `TSWD_BASE2;
    // Code 3 switches the group off so two boards never collide on it; the fixed PFO address is still decoded
    wire grp_on = (base_sel != 2'h3);
    wire hit_sys = grp_on && (bus_req.addr == base_w + `TSWD_OFS_SYS);
    wire hit_lock = grp_on && (bus_req.addr == base_w + `TSWD_OFS_LOCK);
    wire hit_wdog = grp_on && (bus_req.addr == base_w + `TSWD_OFS_WDOG);
    wire hit_istat = grp_on && (bus_req.addr == base_w + `TSWD_OFS_ISTAT);
    wire hit_ien = grp_on && (bus_req.addr == base_w + `TSWD_OFS_IEN);
    wire hit_pfo = (bus_req.addr == `TSWD_ADDR_PFO);

    wire wr_lock = bus_req.wr && hit_lock;
    wire wr_wdog = bus_req.wr && hit_wdog;
    wire wr_istat = bus_req.wr && hit_istat;
    wire wr_ien = bus_req.wr && hit_ien;

    wire [2:0] sel_new = bus_req.wdata[`TSWD_SEL_LSB +: 3];
    wire wd_en_nxt = (wr_wdog && !lock_r) ? bus_req.wdata[`TSWD_EN_BIT] : wd_en_r;
    wire tick = (pre_r == PW'(TICK_CYC - 1));

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // Reset values are sliced out of the whole-register defaults
            lock_r <= 1'(`TSWD_RST_LOCK >> `TSWD_LOCK_BIT);
            hclr_n_r <= 1'(`TSWD_RST_LOCK >> `TSWD_HCLR_BIT);
            wd_en_r <= 1'(`TSWD_RST_WDOG >> `TSWD_EN_BIT);
            wd_sel_r <= 3'(`TSWD_RST_WDOG >> `TSWD_SEL_LSB);
            ien_r <= 2'h0;
        end else begin
            if (wr_lock) begin
                lock_r <= bus_req.wdata[`TSWD_LOCK_BIT];
                hclr_n_r <= bus_req.wdata[`TSWD_HCLR_BIT];
            end
            wd_en_r <= wd_en_nxt;
            if (wr_wdog) begin
                wd_sel_r <= sel_new;
            end
            if (wr_ien) begin
                ien_r <= bus_req.wdata[1:0];
            end
        end
    end

    // ----------------------------------------
    // Tick prescaler
    // ----------------------------------------
    // Restarted on each trigger so the first stage is whole ticks long
    always_ff @(posedge clk_sys) begin
        if (!rst_n || wr_wdog || state_r == tswd_pkg::TSWD_IDLE) begin
            pre_r <= PW'(0);
        end else if (tick) begin
            pre_r <= PW'(0);
        end else begin
            pre_r <= pre_r + PW'(1);
        end
    end

    // ----------------------------------------
    // Two-stage sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        hold_nxt = hold_r;
        wd_evt = 1'b0;
        rst_evt = 1'b0;
        case (state_r)
            tswd_pkg::TSWD_IDLE: begin
                cnt_nxt = cnt_r;
            end
            tswd_pkg::TSWD_ARM: begin
                if (tick && cnt_r == CW'(1)) begin
                    state_nxt = tswd_pkg::TSWD_GRACE;
                    cnt_nxt = CW'(`TSWD_S2_TICKS);
                    wd_evt = 1'b1;
                end else if (tick) begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            tswd_pkg::TSWD_GRACE: begin
                if (tick && cnt_r == CW'(1)) begin
                    state_nxt = tswd_pkg::TSWD_RESET;
                    hold_nxt = HW'(RST_HOLD - 1);
                    rst_evt = 1'b1;
                end else if (tick) begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            tswd_pkg::TSWD_RESET: begin
                if (hold_r == HW'(0)) begin
                    state_nxt = tswd_pkg::TSWD_IDLE;
                end else begin
                    hold_nxt = hold_r - HW'(1);
                end
            end
            default: begin
                state_nxt = tswd_pkg::TSWD_IDLE;
            end
        endcase
        // A reset already on its way out is not recalled
        if (state_r != tswd_pkg::TSWD_RESET) begin
            if (wr_wdog && wd_en_nxt) begin
                state_nxt = tswd_pkg::TSWD_ARM;
                cnt_nxt = s1_period(sel_new);
                wd_evt = 1'b0;
                rst_evt = 1'b0;
            end else if (!wd_en_nxt) begin
                state_nxt = tswd_pkg::TSWD_IDLE;
                wd_evt = 1'b0;
                rst_evt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= tswd_pkg::TSWD_IDLE;
            cnt_r <= CW'(0);
            hold_r <= HW'(0);
            mrst_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            mrst_r <= (state_nxt == tswd_pkg::TSWD_RESET);
        end
    end

    // ----------------------------------------
    // Reset history
    // ----------------------------------------
    // Survives the board reset it caused; power-up or a zero written to the history-clear bit clears it
    always_ff @(posedge clk_sys) begin
        if (!por_n || !hclr_n_r) begin
            wdo_r <= 1'b0;
        end else if (rst_evt) begin
            wdo_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Interrupt status and power-fail output
    // ----------------------------------------
    wire [1:0] live = {bat_low, state_r == tswd_pkg::TSWD_GRACE};
    wire [1:0] w1c = wr_istat ? bus_req.wdata[1:0] : 2'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_int
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    istat_r[gi] <= 1'b0;
                end else if (ien_r[gi]) begin
                    istat_r[gi] <= live[gi] | (istat_r[gi] & ~w1c[gi]);
                end else begin
                    istat_r[gi] <= live[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            nmi_r <= 1'b0;
            pfo_n_r <= 1'b1;
        end else begin
            nmi_r <= |(istat_r & ien_r);
            pfo_n_r <= ~bat_low;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    wire [7:0] rd_sys = 8'({wdo_r, sup_fail});
    wire [7:0] rd_lock = 8'({lock_r, 1'b0, hclr_n_r});
    wire [7:0] rd_wdog = {wd_en_r, wd_sel_r, 4'h0};
    wire [7:0] rd_pfo = 8'({pfo_n_r, 1'b0});
    wire [7:0] rd_val = hit_sys ? rd_sys :
                        hit_lock ? rd_lock :
                        hit_wdog ? rd_wdog :
                        hit_istat ? 8'(istat_r) :
                        hit_ien ? 8'(ien_r) :
                        hit_pfo ? rd_pfo : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !bus_req.rd) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_val;
        end
    end

    assign bus_rdata = rdata_r;
    assign nmi_irq = nmi_r;
    assign master_reset = mrst_r;
    assign power_fail_out_n = pfo_n_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Helper counters turn long durations into a single compare
    // instead of a long repetition that the tools would unroll
    int unsigned grace_cyc;
    int unsigned tick_gap;
    always_ff @(posedge clk_sys) begin
        grace_cyc <= (state_r == tswd_pkg::TSWD_GRACE) ? grace_cyc + 1 : 0;
        tick_gap <= (tick || wr_wdog || state_r == tswd_pkg::TSWD_IDLE) ? 0 : tick_gap + 1;
    end

    sequence seq_trig;
        wr_wdog && wd_en_nxt && state_r != tswd_pkg::TSWD_RESET;
    endsequence

    sequence seq_expire;
        state_r == tswd_pkg::TSWD_ARM ##1 state_r == tswd_pkg::TSWD_GRACE;
    endsequence

    AST_RST_OFF: assert property (!$past(rst_n) |-> !wd_en_r && state_r == tswd_pkg::TSWD_IDLE)
        else $error("watchdog not disabled after reset");
    AST_TRIG_LOAD: assert property (seq_trig |=> state_r == tswd_pkg::TSWD_ARM
        && cnt_r == s1_period($past(sel_new)))
        else $error("trigger did not reload counter");
    AST_SEL_PERIOD: assert property (seq_trig ##0 sel_new == 3'h7 |=> cnt_r == CW'(262144))
        else $error("longest select code gives wrong period");
    AST_SEL_STORE: assert property (wr_wdog |=> wd_sel_r == $past(sel_new))
        else $error("time-out select not stored");
    AST_LOCK_HOLD: assert property (lock_r && wr_wdog |=> $stable(wd_en_r))
        else $error("enable changed while locked");
    AST_EXPIRE: assert property (state_r == tswd_pkg::TSWD_ARM && cnt_r == CW'(1) && tick
        && !wr_wdog && wd_en_r |=> state_r == tswd_pkg::TSWD_GRACE)
        else $error("expiry at zero missed");
    AST_NMI: assert property (seq_expire ##0 ien_r[0] && !wr_ien |=> ##1 nmi_irq)
        else $error("enabled NMI not raised");
    AST_STAGE2: assert property (rst_evt |-> grace_cyc == 8 * TICK_CYC - 1)
        else $error("second stage length wrong");
    AST_TICK: assert property (tick |-> tick_gap == TICK_CYC - 1)
        else $error("tick period wrong");
    AST_HISTORY: assert property (rst_evt && hclr_n_r && por_n |=> wdo_r ##1 master_reset)
        else $error("watchdog reset not latched");
    AST_HCLR: assert property (!hclr_n_r |=> !wdo_r)
        else $error("history not cleared");
    AST_HOLD: assert property (state_r == tswd_pkg::TSWD_RESET && hold_r != HW'(0) |=> master_reset)
        else $error("master reset released early");
    AST_CANCEL: assert property ((state_r == tswd_pkg::TSWD_GRACE) and seq_trig |=> !master_reset
        && state_r == tswd_pkg::TSWD_ARM)
        else $error("trigger did not cancel second stage");
    AST_DISABLED: assert property (!wd_en_r && state_r != tswd_pkg::TSWD_RESET
        |-> state_r == tswd_pkg::TSWD_IDLE && !rst_evt)
        else $error("disabled watchdog still running");
    AST_LATCH: assert property (ien_r[1] && istat_r[1] && !w1c[1] |=> istat_r[1])
        else $error("enabled source not latched");
    AST_PFO: assert property (pins_async.battery_low [*3] |=> !power_fail_out_n)
        else $error("power-fail output not low");
    AST_BASE: assert property (bus_req.rd && hit_wdog |=> bus_rdata == {wd_en_r, wd_sel_r, 4'h0})
        else $error("watchdog register read wrong");
    AST_SYS: assert property (bus_req.rd && hit_sys |=> bus_rdata[0] == $past(sup_fail))
        else $error("power-fail status bit wrong");

endmodule
